// >>> nfc_framer.v
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "nfc_framer_map.vh"
module nfc_framer #(
	parameter FIFO_AW = 5,
	parameter CA_CYCLES = `CA_CYCLES,
	parameter IRFG_CYCLES = `IRFG_CYCLES,
	parameter ARFG_CYCLES = `ARFG_CYCLES
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// RF field control
	input wire ext_field_i,
	output reg tx_en_o,
	output reg ca_threshold_sel_o,
	output reg field_detector_enable_o,
	output reg am_channel_en_o,
	output reg pm_channel_en_o,
	// Transmit byte stream to modulator
	output reg [7:0] tx_data_o,
	output wire tx_valid_o,
	input wire tx_ready_i,
	// Receive byte stream from demodulator
	input wire [7:0] rx_data_i,
	input wire rx_valid_i,
	input wire rx_end_i,
	output wire rx_active_o
);

	localparam DEPTH = 1 << FIFO_AW;
	// Sequencer states
	localparam S_IDLE = 3'd0, S_CA = 3'd1, S_GUARD = 3'd2, S_TX = 3'd3;
	localparam S_HOLD = 3'd4, S_NRT = 3'd5, S_MRT = 3'd6, S_RX = 3'd7;
	// Transmit framer states
	localparam T_IDLE = 4'd0, T_PRE = 4'd1, T_SYNC1 = 4'd2, T_SYNC2 = 4'd3, T_SB = 4'd4;
	localparam T_LEN = 4'd5, T_DATA = 4'd6, T_CRC1 = 4'd7, T_CRC2 = 4'd8;
	// Receive framer states
	localparam R_IDLE = 3'd0, R_HUNT = 3'd1, R_SYNC2 = 3'd2, R_SB = 3'd3;
	localparam R_LEN = 3'd4, R_DATA = 3'd5, R_CHECK = 3'd6, R_RAW = 3'd7;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	reg [1:0] ph; // Data phase step: 0 none, 1 wait, 2 done
	reg [4:0] a_idx; // Latched word index
	reg a_wr; // Latched direction
	wire wr = (ph == 2'd1) && a_wr;
	wire rd = (ph == 2'd1) && !a_wr;

	assign hreadyout_o = (ph != 2'd1);
	assign hresp_o = 1'b0;

	// Address phase capture, one wait state per transfer
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			ph <= 2'd0;
			a_idx <= 5'h00;
			a_wr <= 1'b0;
		end else if (hsel_i && htrans_i[1] && hready_i) begin
			ph <= 2'd1;
			a_idx <= haddr_i[6:2];
			a_wr <= hwrite_i;
		end else if (ph == 2'd1) begin
			ph <= 2'd2;
		end else if (hready_i) begin
			ph <= 2'd0;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	reg [1:0] mode; // Operating mode
	reg [1:0] rate; // 0 fc/128, 1 fc/64, 2 fc/32
	reg targ; // Target mode bit, kept for host readback
	reg auto_response_ca_enable;
	reg response_slot_count_lo;
	reg response_slot_count_hi;
	reg transport_frame_106_enable;
	reg [7:0] tx_count; // Bytes taken from FIFO per frame
	reg [7:0] hold_t; // Field hold after a message
	reg [7:0] mrt_t; // Mask receive time
	reg [15:0] nrt_t; // No-response time
	reg [8:0] events; // Sticky event flags
	reg [8:0] ev_seq; // Event pulses from sequencer
	reg [8:0] ev_rx; // Event pulses from receiver

	wire [2:0] cmd = (wr && a_idx == `REG_CMD) ? hwdata_i[2:0] : 3'h0;
	wire active = (mode == `MODE_ACTIVE);
	wire framed = (mode == `MODE_FRAME) || (active && rate != 2'h0);
	wire tf = transport_frame_106_enable && rate == 2'h0 && (mode == `MODE_14443A || active);

	// Register writes and command side effects
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			mode <= `MODE_14443A;
			rate <= 2'h0;
			targ <= 1'b0;
			auto_response_ca_enable <= 1'b0;
			response_slot_count_lo <= 1'b0;
			response_slot_count_hi <= 1'b0;
			transport_frame_106_enable <= 1'b0;
			field_detector_enable_o <= 1'b0;
			am_channel_en_o <= 1'b0;
			pm_channel_en_o <= 1'b0;
			tx_count <= 8'h00;
			hold_t <= `RST_HOLD;
			mrt_t <= `RST_MRT;
			nrt_t <= `RST_NRT;
		end else begin
			if (wr && a_idx == `REG_MODE) begin
				mode <= hwdata_i[1:0];
				rate <= hwdata_i[3:2];
				targ <= hwdata_i[4];
				auto_response_ca_enable <= hwdata_i[5];
				response_slot_count_lo <= hwdata_i[6];
				response_slot_count_hi <= hwdata_i[7];
				if (hwdata_i[1:0] == `MODE_ACTIVE) begin
					field_detector_enable_o <= 1'b1;
				end
			end
			if (wr && a_idx == `REG_SETUP) begin
				transport_frame_106_enable <= hwdata_i[0];
				am_channel_en_o <= hwdata_i[1];
				pm_channel_en_o <= hwdata_i[2];
				field_detector_enable_o <= hwdata_i[3];
			end
			if (wr && a_idx == `REG_TXCOUNT) begin
				tx_count <= hwdata_i[7:0];
			end
			if (wr && a_idx == `REG_TIMER) begin
				hold_t <= hwdata_i[7:0];
				mrt_t <= hwdata_i[15:8];
				nrt_t <= hwdata_i[31:16];
			end
			if (cmd == `CMD_ANALOG_PRESET) begin
				am_channel_en_o <= 1'b1;
				pm_channel_en_o <= 1'b0;
				if (active) begin
					transport_frame_106_enable <= 1'b1;
				end
			end
		end
	end

	// Event flags: write one to clear, a new event wins over the clear
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			events <= 9'h000;
		end else if (wr && a_idx == `REG_EVENT) begin
			events <= (events & ~hwdata_i[8:0]) | ev_seq | ev_rx;
		end else begin
			events <= events | ev_seq | ev_rx;
		end
	end

	// ----------------------------------------
	// Byte FIFO shared by host, transmitter and receiver
	// ----------------------------------------
	reg [7:0] mem [0:DEPTH-1];
	reg [FIFO_AW:0] wp;
	reg [FIFO_AW:0] rp;
	reg [3:0] tstate;
	reg [2:0] rstate;
	reg rx_push; // Receiver stores current byte
	wire [FIFO_AW:0] level = wp - rp;
	wire full = (level == DEPTH[FIFO_AW:0]);
	wire tx_acc = tx_valid_o && tx_ready_i;
	wire host_push = wr && a_idx == `REG_FIFO && !full;
	wire push = (rx_push || host_push) && !full;
	wire pop = ((rd && a_idx == `REG_FIFO) || (tx_acc && tstate == T_DATA)) && (wp != rp);

	// Pointer update and storage, receiver has priority over host
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			wp <= {(FIFO_AW+1){1'b0}};
			rp <= {(FIFO_AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wp[FIFO_AW-1:0]] <= rx_push ? rx_data_i : hwdata_i[7:0];
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
		end
	end

	// Read data registered in the wait cycle, unmapped reads give zero
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			hrdata_o <= 32'h00000000;
		end else if (rd) begin
			case (a_idx)
				`REG_MODE: hrdata_o <= {24'h0, response_slot_count_hi, response_slot_count_lo,
					auto_response_ca_enable, targ, rate, mode};
				`REG_SETUP: hrdata_o <= {28'h0, field_detector_enable_o, pm_channel_en_o,
					am_channel_en_o, transport_frame_106_enable};
				`REG_TXCOUNT: hrdata_o <= {24'h0, tx_count};
				`REG_FIFO: hrdata_o <= {24'h0, mem[rp[FIFO_AW-1:0]]};
				`REG_TIMER: hrdata_o <= {nrt_t, mrt_t, hold_t};
				`REG_EVENT: hrdata_o <= {23'h0, events};
				`REG_STATUS: hrdata_o <= {16'h0, {(7-FIFO_AW){1'b0}}, level, tstate, rstate, tx_en_o};
				default: hrdata_o <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Shared CRC engine
	// ----------------------------------------
	reg tx_go; // Start of a transmit frame
	reg rx_arm; // Start of receive observation
	wire [15:0] crc;
	wire crc_tx = tx_acc && (tstate == T_LEN || tstate == T_DATA);
	wire crc_rx = rx_valid_i && (rstate == R_LEN || rstate == R_DATA);

	nfc_crc16 u_crc (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.init_i(tx_go || rx_arm),
		.preset_i(framed ? `CRC_PRESET_212 : `CRC_PRESET_106),
		.en_i(crc_tx || crc_rx),
		.data_i(crc_tx ? tx_data_o : rx_data_i),
		.crc_o(crc)
	);

	// ----------------------------------------
	// Transmit framer
	// ----------------------------------------
	reg [7:0] tcnt;
	reg tx_done;
	assign tx_valid_o = (tstate != T_IDLE);

	// Byte presented for each framing step
	always @* begin
		case (tstate)
			T_PRE: tx_data_o = 8'h00;
			T_SYNC1: tx_data_o = `SYNC_BYTE_1;
			T_SYNC2: tx_data_o = `SYNC_BYTE_2;
			T_SB: tx_data_o = `START_BYTE;
			T_LEN: tx_data_o = tx_count + 8'h01;
			T_DATA: tx_data_o = mem[rp[FIFO_AW-1:0]];
			T_CRC1: tx_data_o = crc[15:8];
			T_CRC2: tx_data_o = crc[7:0];
			default: tx_data_o = 8'h00;
		endcase
	end

	// Frame sequence advances on each accepted byte
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			tstate <= T_IDLE;
			tcnt <= 8'h00;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			case (tstate)
				T_IDLE: begin
					if (tx_go) begin
						tcnt <= `PREAMBLE_BYTES - 8'h01;
						if (framed) begin
							tstate <= T_PRE;
						end else if (tf) begin
							tstate <= T_SB;
						end else begin
							tstate <= T_LEN;
						end
					end
				end
				T_PRE: if (tx_acc) begin
					tcnt <= tcnt - 8'h01;
					if (tcnt == 8'h00) begin
						tstate <= T_SYNC1;
					end
				end
				T_SYNC1: if (tx_acc) begin
					tstate <= T_SYNC2;
				end
				T_SYNC2, T_SB: if (tx_acc) begin
					tstate <= T_LEN;
				end
				T_LEN: if (tx_acc) begin
					tcnt <= tx_count;
					tstate <= (tx_count != 8'h00) ? T_DATA : T_CRC1;
				end
				T_DATA: if (tx_acc) begin
					tcnt <= tcnt - 8'h01;
					if (tcnt == 8'h01) begin
						tstate <= T_CRC1;
					end
				end
				T_CRC1: if (tx_acc) begin
					tstate <= T_CRC2;
				end
				T_CRC2: if (tx_acc) begin
					tstate <= T_IDLE;
					tx_done <= 1'b1;
				end
				default: tstate <= T_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Field and response sequencer
	// ----------------------------------------
	reg fd_s1;
	reg field; // Synchronised external field level
	reg [2:0] seq;
	reg [15:0] cnt;
	reg resp; // Guard time is the active one

	// Two-stage synchroniser for the detector pin
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			fd_s1 <= 1'b0;
			field <= 1'b0;
		end else begin
			fd_s1 <= ext_field_i;
			field <= fd_s1;
		end
	end

	wire ready_cmd = (seq == S_IDLE) || (seq == S_RX && !active);

	// Collision avoidance, guard, hold and response timing
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			seq <= S_IDLE;
			cnt <= 16'h0000;
			resp <= 1'b0;
			tx_en_o <= 1'b0;
			ca_threshold_sel_o <= 1'b0;
			tx_go <= 1'b0;
			rx_arm <= 1'b0;
			ev_seq <= 9'h000;
		end else begin
			tx_go <= 1'b0;
			rx_arm <= 1'b0;
			ev_seq <= 9'h000;
			cnt <= cnt - 16'h0001;
			case (seq)
				S_IDLE, S_RX: begin
					if (ready_cmd && (cmd == `CMD_INIT_FIELD_ON || cmd == `CMD_RESP_FIELD_ON)) begin
						seq <= S_CA;
						resp <= (cmd == `CMD_RESP_FIELD_ON);
						cnt <= CA_CYCLES[15:0];
						ca_threshold_sel_o <= 1'b1;
					end else if (ready_cmd && cmd == `CMD_TX_WITH_CRC) begin
						seq <= S_TX;
						tx_go <= 1'b1;
					end else if (seq == S_RX && active && !field) begin
						ev_seq[`EV_EOF] <= 1'b1;
						if (auto_response_ca_enable) begin
							seq <= S_CA;
							resp <= 1'b1;
							cnt <= CA_CYCLES[15:0];
							ca_threshold_sel_o <= 1'b1;
						end else begin
							seq <= S_IDLE;
						end
					end else if (seq == S_RX && !active && rstate == R_IDLE) begin
						seq <= S_IDLE;
					end
				end
				S_CA: begin
					if (field) begin
						ev_seq[`EV_CAC] <= 1'b1;
						ca_threshold_sel_o <= 1'b0;
						seq <= S_IDLE;
					end else if (cnt == 16'h0000) begin
						tx_en_o <= 1'b1;
						cnt <= resp ? ARFG_CYCLES[15:0] : IRFG_CYCLES[15:0];
						seq <= S_GUARD;
					end
				end
				S_GUARD: if (cnt == 16'h0000) begin
					ev_seq[`EV_CAT] <= 1'b1;
					ca_threshold_sel_o <= 1'b0;
					seq <= S_IDLE;
				end
				S_TX: if (tx_done) begin
					ev_seq[`EV_TX_END] <= 1'b1;
					if (active) begin
						cnt <= {8'h00, hold_t};
						seq <= S_HOLD;
					end else begin
						rx_arm <= 1'b1;
						seq <= S_RX;
					end
				end
				S_HOLD: if (cnt == 16'h0000) begin
					tx_en_o <= 1'b0;
					cnt <= nrt_t;
					seq <= S_NRT;
				end
				S_NRT: begin
					if (field) begin
						ev_seq[`EV_EON] <= 1'b1;
						cnt <= {8'h00, mrt_t};
						seq <= S_MRT;
					end else if (cnt == 16'h0000) begin
						ev_seq[`EV_NRE] <= 1'b1;
						seq <= S_IDLE;
					end
				end
				S_MRT: if (cnt == 16'h0000) begin
					rx_arm <= 1'b1;
					seq <= S_RX;
				end
				default: seq <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Receive framer
	// ----------------------------------------
	reg [8:0] rcnt; // Bytes left: payload plus two CRC bytes
	reg zero_seen; // Preamble byte seen just before
	assign rx_active_o = (rstate != R_IDLE);

	// Store decision for the incoming byte
	always @* begin
		case (rstate)
			R_LEN: rx_push = rx_valid_i;
			R_DATA: rx_push = rx_valid_i && (rcnt > 9'd2);
			R_RAW: rx_push = rx_valid_i;
			default: rx_push = 1'b0;
		endcase
	end

	// Preamble hunt, sync and start byte checks, length count
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			rstate <= R_IDLE;
			rcnt <= 9'h000;
			zero_seen <= 1'b0;
			ev_rx <= 9'h000;
		end else begin
			ev_rx <= 9'h000;
			case (rstate)
				R_IDLE: if (rx_arm) begin
					zero_seen <= 1'b0;
					rstate <= framed ? R_HUNT : (tf ? R_SB : R_RAW);
				end
				R_HUNT: if (rx_valid_i) begin
					zero_seen <= (rx_data_i == 8'h00);
					if (zero_seen && rx_data_i == `SYNC_BYTE_1) begin
						rstate <= R_SYNC2;
					end
				end
				R_SYNC2: if (rx_valid_i) begin
					rstate <= (rx_data_i == `SYNC_BYTE_2) ? R_LEN : R_HUNT;
				end
				R_SB: if (rx_valid_i) begin
					if (rx_data_i != `START_BYTE) begin
						ev_rx[`EV_SOFT_FRAME] <= 1'b1;
					end
					rstate <= R_LEN;
				end
				R_LEN: if (rx_valid_i) begin
					rcnt <= {1'b0, rx_data_i} + 9'd1;
					rstate <= R_DATA;
				end
				R_DATA: if (rx_valid_i) begin
					rcnt <= rcnt - 9'd1;
					if (rcnt == 9'd1) begin
						rstate <= R_CHECK;
					end
				end
				R_CHECK: begin
					ev_rx[`EV_RX_END] <= 1'b1;
					ev_rx[`EV_CRC_ERR] <= (crc != 16'h0000);
					rstate <= R_IDLE;
				end
				R_RAW: if (rx_end_i) begin
					ev_rx[`EV_RX_END] <= 1'b1;
					rstate <= R_IDLE;
				end
				default: rstate <= R_IDLE;
			endcase
		end
	end

endmodule

// >>> nfc_framer_map.vh
// Function
// - Frame mode, or active above 106 kb/s: after transmit, scan receive stream for preamble
// - After sync, store length and payload; check CRC
// - Sync bytes are B2h then 4Dh
// - Field-on command: avoidance, field on, guard, done
// - External field: collision event, transmitter stays off
// - Transport framing at 106 kb/s when enabled, in 14443A or active mode
// - Transport transmit: start byte, length, data, CRC
// - Length byte equals byte count plus one
// - Transport receive: check start byte, store, check CRC
// - Bad start byte: keep storing, flag soft error
// - Active: field commands and automatic response avoidance
// - Active mode enables detector; threshold per phase
// - Active: field off after hold time
// - Preset enables amplitude channel, disables phase channel
// - Preset sets transport framing enable in active mode
// - After field off: no-response timer, timeout event
// - Target field seen: event, mask timer, then receive
// - Target field lost: event, then response field-on if automatic response is enabled, else idle
`ifndef NFC_FRAMER_MAP_VH
`define NFC_FRAMER_MAP_VH

// ----------------------------------------
// Register word indices, byte address is four times
// ----------------------------------------
`define REG_MODE 5'h00
`define REG_SETUP 5'h01
`define REG_TXCOUNT 5'h02
`define REG_CMD 5'h03
`define REG_FIFO 5'h04
`define REG_TIMER 5'h05
`define REG_EVENT 5'h06
`define REG_STATUS 5'h07

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define MODE_14443A 2'h0
`define MODE_FRAME 2'h1
`define MODE_ACTIVE 2'h2
`define CMD_INIT_FIELD_ON 3'h1
`define CMD_RESP_FIELD_ON 3'h2
`define CMD_TX_WITH_CRC 3'h3
`define CMD_ANALOG_PRESET 3'h4
`define EV_CAT 0
`define EV_CAC 1
`define EV_SOFT_FRAME 2
`define EV_NRE 3
`define EV_EON 4
`define EV_EOF 5
`define EV_RX_END 6
`define EV_CRC_ERR 7
`define EV_TX_END 8

// ----------------------------------------
// Frame bytes and reset values
// ----------------------------------------
`define SYNC_BYTE_1 8'hb2
`define SYNC_BYTE_2 8'h4d
`define START_BYTE 8'hf0
`define PREAMBLE_BYTES 8'h06
`define CRC_PRESET_106 16'h6363
`define CRC_PRESET_212 16'h0000
`define RST_HOLD 8'h10
`define RST_MRT 8'h10
`define RST_NRT 16'h0400

// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define CA_CYCLES 16'h0040
`define IRFG_CYCLES 16'h0080
`define ARFG_CYCLES 16'h0040

`endif

// >>> nfc_crc16.v
`timescale 1ns/10ps
module nfc_crc16 (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Control
	input wire init_i,
	input wire [15:0] preset_i,
	input wire en_i,
	input wire [7:0] data_i,
	// Result
	output reg [15:0] crc_o
);

	// Bytewise CRC-16, polynomial 1021h, most significant bit first
	function [15:0] crc_step;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c ^ {d, 8'h00};
			for (i = 0; i < 8; i = i + 1) begin
				r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
			end
			crc_step = r;
		end
	endfunction

	// Load preset at frame start, fold in each byte
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			crc_o <= 16'h0000;
		end else if (init_i) begin
			crc_o <= preset_i;
		end else if (en_i) begin
			crc_o <= crc_step(crc_o, data_i);
		end
	end

endmodule

// >>> nfc_framer_checker.sv
`timescale 1ns/10ps
module nfc_framer_checker #(
	parameter CA_CYCLES = 8
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Bus handshake
	input wire hsel_i,
	input wire [1:0] htrans_i,
	input wire hready_i,
	input wire hreadyout_o,
	input wire hresp_o,
	// Field and byte streams
	input wire tx_en_o,
	input wire ca_threshold_sel_o,
	input wire [7:0] tx_data_o,
	input wire tx_valid_o,
	input wire tx_ready_i,
	input wire rx_active_o
);
	// ------------
	// Properties
	// ------------
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// One wait state, then ready again
	sequence s_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_bus_wait: assert property (hsel_i && htrans_i[1] && hready_i |=> s_wait)
		else $error("bus answer not after one wait state");
	a_resp_okay: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !tx_en_o && !tx_valid_o && hreadyout_o)
		else $error("outputs active after reset");
	a_ca_field_off: assert property ($rose(ca_threshold_sel_o) |-> !tx_en_o [*8])
		else $error("field on before avoidance ended");
	a_ca_bounded: assert property ($rose(ca_threshold_sel_o) |-> ##[1:60] !ca_threshold_sel_o)
		else $error("avoidance threshold held too long");
	a_ca_no_tx: assert property (ca_threshold_sel_o |-> !tx_valid_o)
		else $error("transmit during field-on command");
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("transmit byte changed while stalled");
	a_tx_rx_apart: assert property (tx_valid_o |-> !rx_active_o)
		else $error("receiver armed during transmit");
	a_field_drop: assert property ($fell(tx_en_o) |-> !tx_valid_o)
		else $error("field dropped inside a message");
endmodule

// >>> nfc_rf_peer.sv
`timescale 1ns/10ps
module nfc_rf_peer (
	// Clock
	input wire clock_i,
	// Bytes from the modulator
	input wire [7:0] tx_data_i,
	input wire tx_valid_i,
	output reg tx_ready_o,
	// Bytes to the demodulator
	output reg [7:0] rx_data_o,
	output reg rx_valid_o,
	// Target field at the detector
	output reg ext_field_o
);
	// ------------
	// Queues and pacing
	// ------------
	logic [7:0] got[$]; // Bytes taken from the modulator
	logic [7:0] to_send[$]; // Reply bytes still to send
	integer seed = 33353; // Pacing seed
	integer gap = 0; // Idle cycles before next reply byte
	initial begin
		tx_ready_o = 1'b0;
		rx_data_o = 8'h3c;
		rx_valid_o = 1'b0;
		ext_field_o = 1'b0;
	end
	// Stall the modulator at random; send reply bytes with random gaps
	always @(posedge clock_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_data_i);
		tx_ready_o <= 1'($random(seed));
		if (gap == 0 && to_send.size() > 0) begin
			rx_data_o <= to_send.pop_front();
			rx_valid_o <= 1'b1;
			gap <= $random(seed) & 3;
		end else begin
			// Idle line toggles so no stale byte shows
			rx_data_o <= ~rx_data_o;
			rx_valid_o <= 1'b0;
			gap <= (gap > 0) ? gap - 1 : 0;
		end
	end
endmodule

// >>> test_nfcip1_initiator_framer.sv
`timescale 1ns/10ps
`include "nfc_framer_map.vh"
module test_nfcip1_initiator_framer;
	// ------------
	// Signals
	// ------------
	reg clock_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [2:0] hsize = 3'h0;
	reg rx_end = 1'b0;
	wire [31:0] hrdata;
	wire hready, hresp, tx_en, ca_sel, fd_en, am_en, pm_en;
	wire tx_valid, tx_ready, rx_valid, rx_active, field;
	wire [7:0] tx_data, rx_data;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	integer seed = 33353;
	integer n, h, i;
	logic [7:0] exp_q[$]; // Model of frame bytes
	logic [31:0] q; // Last read data
	logic [31:0] modes[4] = '{32'h0, 32'h0, 32'h5, 32'h9};
	always #4 clock_i = ~clock_i;
	nfc_framer #(.CA_CYCLES(8), .IRFG_CYCLES(16), .ARFG_CYCLES(8)) dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.ext_field_i(field), .tx_en_o(tx_en), .ca_threshold_sel_o(ca_sel),
		.field_detector_enable_o(fd_en), .am_channel_en_o(am_en), .pm_channel_en_o(pm_en),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_end_i(rx_end), .rx_active_o(rx_active));
	nfc_rf_peer u_peer (.clock_i(clock_i), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .ext_field_o(field));
	// ------------
	// Tasks
	// ------------
	task wrap_up;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task give_up;
		n_mismatch++;
		wrap_up;
	endtask
	// Wait for hready high at a rising edge
	task wait_ready;
		integer k;
		for (k = 0; k < 9; k++) begin
			@(posedge clock_i);
			if (hready === 1'b1)
				return;
		end
		give_up;
	endtask
	// One single-word transfer
	task bus(input logic w, input logic [4:0] idx, input logic [31:0] d);
		@(posedge clock_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= 32'({idx, 2'h0});
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		q = hrdata;
	endtask
	// Poll an event flag, then clear it
	task wait_ev(input integer b);
		integer k;
		for (k = 0; k < 400; k++) begin
			bus(1'b0, `REG_EVENT, 32'h0);
			if (q[b] === 1'b1) begin
				bus(1'b1, `REG_EVENT, 32'h1 << b);
				return;
			end
		end
		give_up;
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
		integer j;
		c = c ^ {d, 8'h00};
		for (j = 0; j < 8; j++)
			c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		return c;
	endfunction
	// Model frame: header, length, random data, check bytes
	task build(input logic fr, input logic pl, input logic [7:0] sb);
		integer k;
		logic [15:0] c;
		logic [7:0] b;
		n = 1 + ($random(seed) & 3);
		h = fr ? 8 : (pl ? 0 : 1);
		c = fr ? `CRC_PRESET_212 : `CRC_PRESET_106;
		exp_q.delete();
		if (fr) begin
			repeat (`PREAMBLE_BYTES) exp_q.push_back(8'h00);
			exp_q.push_back(`SYNC_BYTE_1);
			exp_q.push_back(`SYNC_BYTE_2);
		end else if (!pl) begin
			exp_q.push_back(sb);
		end
		for (k = 0; k <= n; k++) begin
			b = k ? 8'($random(seed)) : 8'(n + 1);
			exp_q.push_back(b);
			c = crc(c, b);
		end
		exp_q.push_back(c[15:8]);
		exp_q.push_back(c[7:0]);
	endtask
	task tx_case(input logic fr, input logic pl);
		integer k;
		build(fr, pl, `START_BYTE);
		for (k = h + 1; k <= h + n; k++)
			bus(1'b1, `REG_FIFO, 32'(exp_q[k]));
		bus(1'b1, `REG_TXCOUNT, 32'(n));
		u_peer.got.delete();
		bus(1'b1, `REG_CMD, 32'(`CMD_TX_WITH_CRC));
		wait_ev(`EV_TX_END);
		chk(u_peer.got.size(), exp_q.size());
		foreach (exp_q[m]) chk(u_peer.got[m], exp_q[m]);
	endtask
	task rx_case(input logic fr, input logic bad, input logic pl);
		integer k;
		build(fr, pl, bad ? 8'h0f : `START_BYTE);
		foreach (exp_q[m]) u_peer.to_send.push_back(exp_q[m]);
		// Plain frames end on the demodulator's end strobe
		if (pl) begin
			for (k = 0; u_peer.to_send.size() > 0 || rx_valid; k++) begin
				if (k > 99)
					give_up;
				@(posedge clock_i);
			end
			rx_end <= 1'b1;
			@(posedge clock_i);
			rx_end <= 1'b0;
		end
		wait_ev(`EV_RX_END);
		chk(q[`EV_SOFT_FRAME], bad);
		chk(q[`EV_CRC_ERR], 1'b0);
		bus(1'b1, `REG_EVENT, 32'h1ff);
		for (k = h; k <= h + n + (pl ? 2 : 0); k++) begin
			bus(1'b0, `REG_FIFO, 32'h0);
			chk(q[7:0], exp_q[k]);
		end
	endtask
	// ------------
	// Main sequence
	// ------------
	initial begin
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		u_peer.ext_field_o <= 1'b1;
		bus(1'b1, `REG_MODE, 32'h0);
		bus(1'b1, `REG_CMD, 32'(`CMD_INIT_FIELD_ON));
		wait_ev(`EV_CAC);
		chk(tx_en, 1'b0);
		u_peer.ext_field_o <= 1'b0;
		bus(1'b1, `REG_CMD, 32'(`CMD_INIT_FIELD_ON));
		wait_ev(`EV_CAT);
		chk(tx_en, 1'b1);
		bus(1'b1, `REG_SETUP, 32'h1);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, `REG_MODE, modes[i]);
			tx_case(i > 1, 1'b0);
			rx_case(i > 1, i == 1, 1'b0);
		end
		// Plain 106 kb/s framing once the transport bit is clear
		bus(1'b1, `REG_MODE, 32'h0);
		bus(1'b1, `REG_SETUP, 32'h0);
		tx_case(1'b0, 1'b1);
		rx_case(1'b0, 1'b0, 1'b1);
		// Active loop after a second reset
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		bus(1'b1, `REG_TIMER, 32'h0030_0404);
		bus(1'b1, `REG_MODE, 32'h22);
		chk(fd_en, 1'b1);
		bus(1'b1, `REG_CMD, 32'(`CMD_ANALOG_PRESET));
		chk({am_en, pm_en}, 2'h2);
		bus(1'b0, `REG_SETUP, 32'h0);
		chk(q[0], 1'b1);
		bus(1'b1, `REG_CMD, 32'(`CMD_INIT_FIELD_ON));
		wait_ev(`EV_CAT);
		chk(tx_en, 1'b1);
		tx_case(1'b0, 1'b0);
		wait_ev(`EV_NRE);
		chk(tx_en, 1'b0);
		bus(1'b1, `REG_CMD, 32'(`CMD_RESP_FIELD_ON));
		wait_ev(`EV_CAT);
		chk(tx_en, 1'b1);
		tx_case(1'b0, 1'b0);
		for (i = 0; tx_en !== 1'b0; i++) begin
			if (i > 50)
				give_up;
			@(posedge clock_i);
		end
		u_peer.ext_field_o <= 1'b1;
		wait_ev(`EV_EON);
		repeat (8) @(posedge clock_i);
		rx_case(1'b0, 1'b0, 1'b0);
		u_peer.ext_field_o <= 1'b0;
		wait_ev(`EV_EOF);
		wait_ev(`EV_CAT);
		chk(tx_en, 1'b1);
		// Last command: auto response off, field must stay off after target drops
		bus(1'b1, `REG_MODE, 32'h2);
		tx_case(1'b0, 1'b0);
		u_peer.ext_field_o <= 1'b1;
		wait_ev(`EV_EON);
		repeat (8) @(posedge clock_i);
		u_peer.ext_field_o <= 1'b0;
		wait_ev(`EV_EOF);
		repeat (40) @(posedge clock_i);
		chk(tx_en, 1'b0);
		wrap_up;
	end
endmodule
bind nfc_framer nfc_framer_checker #(.CA_CYCLES(CA_CYCLES)) u_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
	.hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .tx_en_o(tx_en_o),
	.ca_threshold_sel_o(ca_threshold_sel_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .rx_active_o(rx_active_o));
